// ===== core/sbc_mode_pkg.sv
// Constants and types for the mode and wake-up controller
package sbc_mode_pkg;

  typedef enum logic [1:0] {
    MODE_FAILSAFE = 2'h0,
    MODE_NORMAL   = 2'h1,
    MODE_SILENT   = 2'h3,
    MODE_SLEEP    = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    WAKE_IDLE     = 2'h0,
    WAKE_LOW      = 2'h1,
    WAKE_HELD     = 2'h3
  } wake_t;

  typedef enum logic [1:0] {
    SRC_NONE      = 2'h0,
    SRC_BUS_WAKE  = 2'h1,
    SRC_BATT_UV   = 2'h2,
    SRC_WATCHDOG  = 2'h3
  } src_t;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned RESET_TIME_US = 4000;
  localparam int unsigned RESET_CYCLES  = RESET_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WAKE_TIME_US  = 150;
  localparam int unsigned WAKE_CYCLES   = WAKE_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W         = 16;

endpackage

// ===== core/lin_sbc_mode_wake_control.sv
// Operating-mode, wake-up and reset-source control of the bus transceiver chip
`timescale 1ns/1ps
// Functional notes
// - Wake: fall, long dominant, rise, transmit high
// - Silent wake goes Fail-safe, termination on
// - Accepted wake pulls receive pin low
// - Enable after wake goes straight Normal
// - Power-up enters Fail-safe without host
// - Regulator on during Fail-safe
// - Power-up reset output low for 4ms
// - Bus communication off in Fail-safe
// - Stay Fail-safe until enable high
// - Battery loss in Silent/Sleep gives Fail-safe
// - Reset output low forces Fail-safe
// - Fail-safe: data pins encode the source
// - Watchdog active in Fail-safe
// - Normal follows bus; Silent holds pins high
// - Any wake in Silent/Sleep gives Fail-safe
// - Wake source: bus low/low, battery high/low
// - Reset source: undervoltage high/low, watchdog high/high
// - Reset on undervoltage or watchdog, 4ms
// - Regulator off in Sleep
module lin_sbc_mode_wake_control #(
  parameter int unsigned RESET_COUNT = sbc_mode_pkg::RESET_CYCLES,
  parameter int unsigned WAKE_COUNT  = sbc_mode_pkg::WAKE_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic normal_req,
  input  wire logic silent_req,
  input  wire logic sleep_req,
  input  wire logic bus_rx,
  input  wire logic host_txd,
  input  wire logic batt_uv,
  input  wire logic reg_uv,
  input  wire logic watchdog_trip,
  input  wire logic local_wake,
  input  wire logic reset_in,
  output logic      reset_out_n_oe_n,
  output logic      regulator_output,
  output logic      bus_enable,
  output logic      termination_on,
  output logic      watchdog_on,
  output logic      txd_out,
  output logic      txd_oe_n,
  output logic      rxd_out,
  output logic      bus_tx,
  output sbc_mode_pkg::mode_t mode_out
);

  // Counters are CNT_W bits wide; larger counts would wrap
  if (RESET_COUNT < 1 || RESET_COUNT >= (1 << sbc_mode_pkg::CNT_W) ||
      WAKE_COUNT < 1 || WAKE_COUNT >= (1 << sbc_mode_pkg::CNT_W))
  begin
    $error("counts out of range");
  end

  typedef struct packed {
    logic [1:0]               s_en;
    logic [1:0]               s_sil;
    logic [1:0]               s_slp;
    logic [1:0]               s_bus;
    logic [1:0]               s_txd;
    logic [1:0]               s_buv;
    logic [1:0]               s_ruv;
    logic [1:0]               s_wd;
    logic [1:0]               s_lw;
    logic [1:0]               s_rin;
    sbc_mode_pkg::mode_t      mode;
    sbc_mode_pkg::wake_t      wake;
    logic [sbc_mode_pkg::CNT_W-1:0] wcnt;
    logic [sbc_mode_pkg::CNT_W-1:0] rcnt;
    logic                     rst_active;
    logic                     bus_prev;
    logic                     power_lost;
    sbc_mode_pkg::src_t       src;
    logic                     term;
    logic                     rst_oe_n;
    logic                     reg_on;
    logic                     bus_en;
    logic                     wd_on;
    logic                     txd_o;
    logic                     txd_oen;
    logic                     rxd_o;
    logic                     btx;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic en_s;
  logic bus_s;
  logic txd_s;
  logic wake_ok;
  logic any_wake;
  logic reset_low;
  logic rst_event;
  logic [sbc_mode_pkg::CNT_W-1:0] rst_len;
  logic [sbc_mode_pkg::CNT_W-1:0] wake_len;

  assign rst_len  = sbc_mode_pkg::CNT_W'(RESET_COUNT);
  assign wake_len = sbc_mode_pkg::CNT_W'(WAKE_COUNT);
  assign en_s     = state_reg.s_en[1];
  assign bus_s    = state_reg.s_bus[1];
  assign txd_s    = state_reg.s_txd[1];
  // Pin seen low also when another party pulls the shared reset line
  assign reset_low = state_reg.rst_active || state_reg.s_rin[1];
  assign rst_event = state_reg.s_ruv[1] || state_reg.s_wd[1];

  always_comb
  begin
    state_next = state_reg;
    wake_ok    = 1'b0;
    // Two-stage synchronisers on every pin input
    state_next.s_en  = {state_reg.s_en[0],  normal_req};
    state_next.s_sil = {state_reg.s_sil[0], silent_req};
    state_next.s_slp = {state_reg.s_slp[0], sleep_req};
    state_next.s_bus = {state_reg.s_bus[0], bus_rx};
    state_next.s_txd = {state_reg.s_txd[0], host_txd};
    state_next.s_buv = {state_reg.s_buv[0], batt_uv};
    state_next.s_ruv = {state_reg.s_ruv[0], reg_uv};
    state_next.s_wd  = {state_reg.s_wd[0],  watchdog_trip};
    state_next.s_lw  = {state_reg.s_lw[0],  local_wake};
    state_next.s_rin = {state_reg.s_rin[0], reset_in};
    state_next.bus_prev = bus_s;

    // Bus wake filter; dominant is low
    case (state_reg.wake)
      sbc_mode_pkg::WAKE_IDLE:
      begin
        state_next.wcnt = '0;
        // A real falling edge, not a bus already stuck dominant
        if (state_reg.bus_prev && !bus_s && txd_s)
          state_next.wake = sbc_mode_pkg::WAKE_LOW;
      end
      sbc_mode_pkg::WAKE_LOW:
      begin
        if (bus_s || !txd_s)
          state_next.wake = sbc_mode_pkg::WAKE_IDLE;
        else if (state_reg.wcnt >= wake_len - 1'b1)
          state_next.wake = sbc_mode_pkg::WAKE_HELD;
        else
          state_next.wcnt = state_reg.wcnt + 1'b1;
      end
      sbc_mode_pkg::WAKE_HELD:
      begin
        if (!txd_s)
          state_next.wake = sbc_mode_pkg::WAKE_IDLE;
        else if (bus_s)
        begin
          wake_ok = 1'b1;
          state_next.wake = sbc_mode_pkg::WAKE_IDLE;
        end
      end
      default: state_next.wake = sbc_mode_pkg::WAKE_IDLE;
    endcase

    // Only listen for wake-ups in the low-power modes
    any_wake = (state_reg.mode == sbc_mode_pkg::MODE_SILENT ||
                state_reg.mode == sbc_mode_pkg::MODE_SLEEP) &&
               (wake_ok || state_reg.s_lw[1]);

    // Battery loss remembered, acted on once the supply is back
    if ((state_reg.mode == sbc_mode_pkg::MODE_SILENT ||
         state_reg.mode == sbc_mode_pkg::MODE_SLEEP) && state_reg.s_buv[1])
      state_next.power_lost = 1'b1;

    // Reset pulse generator
    if (rst_event)
    begin
      state_next.rst_active  = 1'b1;
      state_next.rcnt        = '0;
      state_next.src = state_reg.s_ruv[1] ? sbc_mode_pkg::SRC_BATT_UV
                                          : sbc_mode_pkg::SRC_WATCHDOG;
    end
    else if (state_reg.rst_active)
    begin
      if (state_reg.rcnt >= rst_len - 1'b1)
        state_next.rst_active = 1'b0;
      else
        state_next.rcnt = state_reg.rcnt + 1'b1;
    end

    // Mode sequencing
    // Reset event wins over a wake in the same cycle, keeping its source code
    if (reset_low || rst_event)
      state_next.mode = sbc_mode_pkg::MODE_FAILSAFE;
    else if (state_reg.power_lost && !state_reg.s_buv[1])
    begin
      state_next.mode       = sbc_mode_pkg::MODE_FAILSAFE;
      state_next.power_lost = 1'b0;
      state_next.src        = sbc_mode_pkg::SRC_BATT_UV;
    end
    else if (any_wake)
    begin
      state_next.mode = sbc_mode_pkg::MODE_FAILSAFE;
      state_next.src  = sbc_mode_pkg::SRC_BUS_WAKE;
      if (wake_ok)
        state_next.term = 1'b1;
    end
    else
    begin
      case (state_reg.mode)
        sbc_mode_pkg::MODE_FAILSAFE:
          if (en_s)
            state_next.mode = sbc_mode_pkg::MODE_NORMAL;
        sbc_mode_pkg::MODE_NORMAL:
          if (state_reg.s_slp[1])
            state_next.mode = sbc_mode_pkg::MODE_SLEEP;
          else if (state_reg.s_sil[1])
            state_next.mode = sbc_mode_pkg::MODE_SILENT;
        sbc_mode_pkg::MODE_SILENT:
          if (state_reg.s_slp[1])
            state_next.mode = sbc_mode_pkg::MODE_SLEEP;
        sbc_mode_pkg::MODE_SLEEP:
          state_next.mode = sbc_mode_pkg::MODE_SLEEP;
        default: state_next.mode = sbc_mode_pkg::MODE_FAILSAFE;
      endcase
    end
    if (state_next.mode == sbc_mode_pkg::MODE_NORMAL)
    begin
      state_next.src  = sbc_mode_pkg::SRC_NONE;
      state_next.term = 1'b1;
    end
    // Termination off in low-power modes, so a bus wake switches it on
    else if (state_next.mode == sbc_mode_pkg::MODE_SILENT ||
             state_next.mode == sbc_mode_pkg::MODE_SLEEP)
      state_next.term = 1'b0;

    // Registered outputs from next mode
    state_next.rst_oe_n = !state_next.rst_active;
    state_next.reg_on  = (state_next.mode != sbc_mode_pkg::MODE_SLEEP);
    state_next.bus_en  = (state_next.mode == sbc_mode_pkg::MODE_NORMAL);
    state_next.wd_on   = (state_next.mode == sbc_mode_pkg::MODE_FAILSAFE) ||
                         (state_next.mode == sbc_mode_pkg::MODE_NORMAL);
    state_next.btx     = 1'b1;
    state_next.txd_oen = 1'b1;
    state_next.txd_o   = 1'b1;
    state_next.rxd_o   = 1'b1;
    case (state_next.mode)
      sbc_mode_pkg::MODE_FAILSAFE:
      begin
        state_next.txd_oen = 1'b0;
        case (state_next.src)
          sbc_mode_pkg::SRC_BUS_WAKE:
          begin
            state_next.txd_o = 1'b0;
            state_next.rxd_o = 1'b0;
          end
          sbc_mode_pkg::SRC_BATT_UV: state_next.rxd_o = 1'b0;
          default: state_next.rxd_o = 1'b1;
        endcase
      end
      sbc_mode_pkg::MODE_NORMAL:
      begin
        state_next.rxd_o = bus_s;
        state_next.btx   = txd_s;
      end
      default: state_next.rxd_o = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg            <= '0;
      state_reg.mode       <= sbc_mode_pkg::MODE_FAILSAFE;
      state_reg.rst_active <= 1'b1;
      state_reg.src        <= sbc_mode_pkg::SRC_BATT_UV;
      state_reg.bus_prev   <= 1'b1;
      state_reg.rst_oe_n   <= 1'b0;
      state_reg.reg_on     <= 1'b1;
      state_reg.wd_on      <= 1'b1;
      state_reg.txd_o      <= 1'b1;
      state_reg.btx        <= 1'b1;
      state_reg.s_bus      <= 2'h3;
    end
    else
      state_reg <= state_next;
  end

  assign reset_out_n_oe_n = state_reg.rst_oe_n;
  assign regulator_output = state_reg.reg_on;
  assign bus_enable       = state_reg.bus_en;
  assign termination_on   = state_reg.term;
  assign watchdog_on      = state_reg.wd_on;
  assign txd_out          = state_reg.txd_o;
  assign txd_oe_n         = state_reg.txd_oen;
  assign rxd_out          = state_reg.rxd_o;
  assign bus_tx           = state_reg.btx;
  assign mode_out         = state_reg.mode;

  sequence s_reset_low;
    reset_low;
  endsequence

  a_reset_forces_failsafe: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_reset_low |=> mode_out == sbc_mode_pkg::MODE_FAILSAFE)
    else $error("reset did not force fail-safe");

  a_wake_accept: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wake_ok && state_reg.mode == sbc_mode_pkg::MODE_SILENT &&
     !reset_low && !rst_event && !state_reg.power_lost)
    |=> mode_out == sbc_mode_pkg::MODE_FAILSAFE && termination_on && !rxd_out && !txd_out)
    else $error("bus wake not handled");

  a_wake_needs_txd: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wake_ok |-> txd_s && bus_s && !state_reg.bus_prev && state_reg.wcnt >= wake_len - 1'b1)
    else $error("wake accepted without conditions");

  a_failsafe_exit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (mode_out == sbc_mode_pkg::MODE_FAILSAFE && !en_s) |=>
      mode_out == sbc_mode_pkg::MODE_FAILSAFE)
    else $error("left fail-safe without enable");

  a_regulator_sleep: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_out == sbc_mode_pkg::MODE_SLEEP |-> !regulator_output)
    else $error("regulator on in sleep");

  a_failsafe_outputs: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_out == sbc_mode_pkg::MODE_FAILSAFE |->
      regulator_output && !bus_enable && watchdog_on && !txd_oe_n)
    else $error("fail-safe outputs wrong");

  a_silent_pins: assert property (@(posedge sys_clk) disable iff (!reset_n)
    mode_out == sbc_mode_pkg::MODE_SILENT |-> txd_out && rxd_out)
    else $error("silent pins not high");

  a_reset_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(state_reg.s_ruv[1]) |=> !reset_out_n_oe_n [*8])
    else $error("reset pulse missing");

endmodule

// ===== bench/host_mcu_model.sv
// Host controller model: mode requests and transmit pin drive
`timescale 1ns/1ps
module host_mcu_model (
  input  wire logic                sys_clk,
  input  wire logic                txd_out,
  input  wire logic                txd_oe_n,
  input  wire sbc_mode_pkg::mode_t mode_out,
  output logic                     normal_req,
  output logic                     silent_req,
  output logic                     sleep_req,
  output logic                     host_txd
);
  logic host_level;
  // Host lets go of the pin while the chip signals its source
  assign host_txd = txd_oe_n ? host_level : txd_out;
  initial
  begin
    normal_req = 1'b0;
    silent_req = 1'b0;
    sleep_req  = 1'b0;
    host_level = 1'b1;
  end
  // Level request held until the mode lands, then dropped
  task automatic request(input logic [1:0] sel, input sbc_mode_pkg::mode_t m, output logic ok);
    int n;
    n = 0;
    @(posedge sys_clk);
    normal_req <= (sel == 2'h0);
    silent_req <= (sel == 2'h1);
    sleep_req  <= (sel == 2'h2);
    // Mode is looked at on the falling edge, where it has settled
    @(negedge sys_clk);
    while (mode_out !== m && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    ok = (mode_out === m);
    @(posedge sys_clk);
    normal_req <= 1'b0;
    silent_req <= 1'b0;
    sleep_req  <= 1'b0;
  endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the mode and wake-up controller
`timescale 1ns/1ps
module testbench;
  localparam int RC = 20;
  localparam int WC = 5;
  logic                sys_clk, reset_n, bus_rx, ok;
  logic [4:0]          ev;
  logic                normal_req, silent_req, sleep_req, host_txd;
  logic                reset_out_n_oe_n, regulator_output, bus_enable, termination_on;
  logic                watchdog_on, txd_out, txd_oe_n, rxd_out, bus_tx;
  sbc_mode_pkg::mode_t mode_out;
  int                  mismatches, check_count;
  int                  cycles = 0;

  lin_sbc_mode_wake_control #(.RESET_COUNT(RC), .WAKE_COUNT(WC)) u_lin_sbc_mode_wake_control (
    .sys_clk(sys_clk), .reset_n(reset_n), .normal_req(normal_req),
    .silent_req(silent_req), .sleep_req(sleep_req), .bus_rx(bus_rx), .host_txd(host_txd),
    .batt_uv(ev[0]), .reg_uv(ev[1]), .watchdog_trip(ev[2]), .local_wake(ev[3]),
    .reset_in(ev[4]), .reset_out_n_oe_n(reset_out_n_oe_n), .regulator_output(regulator_output),
    .bus_enable(bus_enable), .termination_on(termination_on), .watchdog_on(watchdog_on),
    .txd_out(txd_out), .txd_oe_n(txd_oe_n), .rxd_out(rxd_out), .bus_tx(bus_tx),
    .mode_out(mode_out));
  host_mcu_model u_host_mcu_model (
    .sys_clk(sys_clk), .txd_out(txd_out), .txd_oe_n(txd_oe_n), .mode_out(mode_out),
    .normal_req(normal_req), .silent_req(silent_req), .sleep_req(sleep_req),
    .host_txd(host_txd));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ask(input logic [1:0] sel, input sbc_mode_pkg::mode_t m);
    u_host_mcu_model.request(sel, m, ok);
    check(ok, 1'b1);
  endtask
  task automatic expect_mode(input sbc_mode_pkg::mode_t m);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (mode_out !== m && n < 12)
    begin
      @(negedge sys_clk);
      n++;
    end
    check(mode_out, m);
  endtask
  task automatic pulse_ev(input int i, input int n);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    repeat (n) @(posedge sys_clk);
    ev[i] <= 1'b0;
  endtask
  // Counts the low time of the reset line, with sync slack of two cycles
  task automatic pulse_len;
    int n;
    n = 0;
    @(negedge sys_clk);
    while (reset_out_n_oe_n !== 1'b0 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    while (reset_out_n_oe_n === 1'b0 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
      if (n == 5)
        check(mode_out, sbc_mode_pkg::MODE_FAILSAFE);
    end
    check(n >= RC && n <= RC + 2, 1'b1);
  endtask
  task automatic dominant(input int n);
    @(posedge sys_clk);
    bus_rx <= 1'b0;
    repeat (n) @(posedge sys_clk);
    bus_rx <= 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic t_power;
    pulse_len();
    check(mode_out, sbc_mode_pkg::MODE_FAILSAFE);
    check({regulator_output, watchdog_on, bus_enable}, 3'b110);
    check({txd_oe_n, host_txd, rxd_out}, 3'b010);
  endtask
  task automatic t_normal;
    ask(2'h0, sbc_mode_pkg::MODE_NORMAL);
    @(negedge sys_clk);
    check({bus_enable, txd_oe_n}, 2'b11);
    @(posedge sys_clk);
    bus_rx <= 1'b0;
    u_host_mcu_model.host_level <= 1'b0;
    repeat (5) @(negedge sys_clk);
    check({rxd_out, bus_tx}, 2'b00);
    @(posedge sys_clk);
    bus_rx <= 1'b1;
    u_host_mcu_model.host_level <= 1'b1;
    repeat (5) @(negedge sys_clk);
    check({rxd_out, bus_tx}, 2'b11);
  endtask
  task automatic t_silent_wake;
    ask(2'h1, sbc_mode_pkg::MODE_SILENT);
    repeat (4) @(negedge sys_clk);
    check({host_txd, rxd_out, termination_on}, 3'b110);
    // Too short a dominant phase must not wake
    dominant(2);
    check(mode_out, sbc_mode_pkg::MODE_SILENT);
    dominant(WC + 8);
    expect_mode(sbc_mode_pkg::MODE_FAILSAFE);
    check({host_txd, rxd_out, termination_on, txd_oe_n}, 4'b0010);
    ask(2'h0, sbc_mode_pkg::MODE_NORMAL);
  endtask
  task automatic t_sleep(input int i);
    ask(2'h2, sbc_mode_pkg::MODE_SLEEP);
    repeat (4) @(negedge sys_clk);
    check(regulator_output, 1'b0);
    pulse_ev(i, 5);
    expect_mode(sbc_mode_pkg::MODE_FAILSAFE);
    if (i == 0)
      check({host_txd, rxd_out, regulator_output}, 3'b101);
    ask(2'h0, sbc_mode_pkg::MODE_NORMAL);
  endtask
  task automatic t_reset_src(input int i, input logic [1:0] code);
    pulse_ev(i, 1);
    pulse_len();
    repeat (2) @(negedge sys_clk);
    check({host_txd, rxd_out}, code);
    ask(2'h0, sbc_mode_pkg::MODE_NORMAL);
  endtask

  initial
  begin
    reset_n     = 1'b0;
    bus_rx      = 1'b1;
    ev          = 5'h00;
    mismatches  = 0;
    check_count = 0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_power();
    t_normal();
    t_silent_wake();
    t_sleep(0);
    t_sleep(3);
    t_reset_src(2, 2'b11);
    t_reset_src(1, 2'b10);
    pulse_ev(4, 3);
    expect_mode(sbc_mode_pkg::MODE_FAILSAFE);
    end_of_test();
  end
endmodule
